// [bench/ffm_fault_asserts.sv]
module ffm_fault_asserts #(
  parameter int NCH = 24
) (
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic           rail_por,
  input wire logic           tsd2,
  input wire logic           supply_uv,
  input wire logic           ref_fault,
  input wire logic           tsd1,
  input wire logic [15:0]    computed_config_checksum,
  input wire logic [15:0]    stored_config_checksum,
  input wire logic           checksum_valid,
  input wire logic           err_line_out,
  input wire logic           err_line_oe,
  input wire logic [NCH-1:0] channel_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // bus answer
  pready_one_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  pready_setup_a: assert property (psel && !penable |=> pready) else $error("no zero-wait answer");
  slverr_pair_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  // ==========================================
  // fault reactions, two cycles of sync latency
  por_line_a: assert property ((rail_por || tsd2) [*5] |-> err_line_oe && channel_on == '0)
    else $error("reset event not holding line");
  uv_off_a: assert property (supply_uv [*5] |-> channel_on == '0)
    else $error("undervoltage left outputs on");
  ref_off_a: assert property ((ref_fault || tsd1) [*5] |-> channel_on == '0)
    else $error("reference or thermal left outputs on");
  crc_off_a: assert property ((checksum_valid &&
    computed_config_checksum != stored_config_checksum) [*5] |-> channel_on == '0)
    else $error("checksum mismatch left outputs on");
  // open drain: the pin is only ever pulled low
  line_drive_a: assert property (err_line_out == 1'b0)
    else $error("fault line driven high");
endmodule // ffm_fault_asserts

bind ffm_fault_manager ffm_fault_asserts #(.NCH(NCH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .rail_por(rail_por), .tsd2(tsd2), .supply_uv(supply_uv),
  .ref_fault(ref_fault), .tsd1(tsd1), .computed_config_checksum(computed_config_checksum),
  .stored_config_checksum(stored_config_checksum), .checksum_valid(checksum_valid),
  .err_line_out(err_line_out), .err_line_oe(err_line_oe), .channel_on(channel_on));

// [bench/ffm_line_model.sv]
module ffm_line_model (
  input  wire logic oe,
  input  wire logic peer_pull,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // wired fault line, external pull-up
  // any party pulls low
  assign line = !(oe | peer_pull);
endmodule // ffm_line_model

// [bench/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ffm_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er, oe, lo, lin, irq, peer = 0, good = 1;
  logic [4:0]  ev = 0;
  logic [1:0]  pv = 0;
  logic [15:0] cc = 16'h0000;
  logic [23:0] pl = '1, oc = 0, sc = 0, lc = 0, con;
  int          miscompares = 0, checked = 0;
  int          fb[5] = '{FFM_F_LOWSUP, FFM_F_SUPUV, FFM_F_REF, FFM_F_PRETSD, FFM_F_TSD};
  logic [4:0]  act = 5'b10110;
  always #5 pclk = ~pclk;
  ffm_line_model u_line (.oe(oe), .peer_pull(peer), .line(lin));
  ffm_fault_manager #(.NCH(24), .RETRY_CYC(50)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rail_por(pv[0]), .rails_good(good), .tsd2(pv[1]), .low_supply(ev[0]),
    .supply_uv(ev[1]), .ref_fault(ev[2]), .pretsd(ev[3]), .tsd1(ev[4]),
    .computed_config_checksum(cc), .stored_config_checksum(16'h0000),
    .checksum_valid(1'b1), .pwm_long(pl), .open_cmp(oc), .short_cmp(sc), .sls_cmp(lc),
    .err_line_in(lin), .err_line_out(lo), .err_line_oe(oe), .channel_on(con), .irq(irq));
  // ==========================================
  // bus tasks; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(n, rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // watchdog, run needs well under 10k cycles
  initial begin
    #200us;
    miscompares++;
    print_verdict;
  end
  // ==========================================
  // tests
  initial begin
    cyc(4);
    presetn <= 1;
    cyc(6);
    rdc("mask", FFM_MASK_OFS, 0);
    rdc("cfg", FFM_CFG_OFS, 0);
    apb(0, 8'h34, 0);
    chk("unmapped", er, 1);
    wr(FFM_CTRL_OFS, 2);
    wr(FFM_CTRL_OFS, 1);
    wr(FFM_IRQS_OFS, 3);
    wr(FFM_CHEN_OFS, '1);
    wr(FFM_DIAG_OFS, '1);
    wr(FFM_IRQM_OFS, 1);
    cyc(8);
    chk("on", con, 24'hffffff);
    // supply, reference and thermal events, unmasked then masked
    for (int m = 0; m < 2; m++) for (int i = 0; i < 5; i++) begin
      wr(FFM_MASK_OFS, m << fb[i]);
      ev[i] <= 1;
      cyc(8);
      chk("off", con, act[i] ? 0 : 24'hffffff);
      chk("line", oe, act[i] & !m);
      chk("irq", irq, !m);
      ev[i] <= 0;
      cyc(8);
      chk("back", con, 24'hffffff);
      rdc("latched", FFM_FLAG_OFS, (1 << fb[i]) | (!m << 1));
      wr(FFM_CTRL_OFS, 1);
      rdc("selfclr", FFM_CTRL_OFS, 0);
      rdc("cleared", FFM_FLAG_OFS, 0);
      wr(FFM_IRQS_OFS, 3);
      cyc(2);
      chk("irqclr", irq, 0);
    end
    wr(FFM_MASK_OFS, 0);
    // open fault, others-on then one-fails-all-fail
    for (int k = 0; k < 2; k++) begin
      wr(FFM_CFG_OFS, k);
      oc[3] <= 1;
      cyc(8);
      chk("one_fails_all_fail_enable", con, k ? 0 : 24'hfffff7);
      chk("chline", oe, 1);
      rdc("open", FFM_OPEN_OFS, 24'h8);
      rdc("chflag", FFM_FLAG_OFS, 12'h302);
      oc[3] <= 0;
      cyc(120);
      chk("retry", con, 24'hffffff);
      wr(FFM_CTRL_OFS, 1);
    end
    peer <= 1;
    cyc(8);
    chk("peer", con, 0);
    peer <= 0;
    wr(FFM_CFG_OFS, 0);
    // unqualified faults stay silent
    for (int j = 0; j < 2; j++) begin
      pl[2] <= j;
      wr(FFM_DIAG_OFS, j ? 32'hfffffb : '1);
      oc[2] <= 1;
      cyc(8);
      rdc("qual", FFM_OPEN_OFS, 0);
      oc[2] <= 0;
    end
    pl <= '1;
    wr(FFM_DIAG_OFS, '1);
    lc[1] <= 1;
    cyc(8);
    rdc("slsoff", FFM_SLS_OFS, 0);
    wr(FFM_MASK_OFS, 1 << FFM_F_SLS);
    wr(FFM_CFG_OFS, 2);
    cyc(8);
    rdc("sls", FFM_SLS_OFS, 2);
    chk("slsline", oe, 1);
    lc[1] <= 0;
    cyc(120);
    wr(FFM_CTRL_OFS, 1);
    wr(FFM_MASK_OFS, 0);
    // checksum fault holds until clear
    cc <= 16'h0001;
    cyc(8);
    cc <= 16'h0000;
    cyc(8);
    chk("crc", con, 0);
    rdc("crcflag", FFM_FLAG_OFS, 12'h082);
    wr(FFM_CTRL_OFS, 1);
    cyc(8);
    chk("crcclr", con, 24'hffffff);
    // reset events, cleared only by the clear-reset bit
    for (int j = 0; j < 2; j++) begin
      pv[j] <= 1;
      good  <= 0;
      cyc(8);
      chk("porline", oe, 1);
      chk("poroff", con, 0);
      pv[j] <= 0;
      cyc(10);
      rdc("hold", FFM_STAT_OFS, FFM_ST_POR);
      good <= 1;
      cyc(10);
      rdc("state", FFM_STAT_OFS, FFM_ST_RUN);
      wr(FFM_CTRL_OFS, 1);
      apb(0, FFM_FLAG_OFS, 0);
      chk("porflag", rd[FFM_F_RESET], 1);
      wr(FFM_CTRL_OFS, 2);
      apb(0, FFM_FLAG_OFS, 0);
      chk("porclr", rd[FFM_F_RESET], 0);
    end
    print_verdict;
  end
endmodule // tb_top

// [rtl/ffm_fault_manager.sv]
// Our own choices: the register addresses and the APB slave port.
module ffm_fault_manager
  import ffm_pkg::*;
#(
  parameter int NCH       = 24,
  parameter int RETRY_CYC = FFM_RETRY_CYC
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic           rail_por,
  input  wire logic           rails_good,
  input  wire logic           tsd2,
  input  wire logic           low_supply,
  input  wire logic           supply_uv,
  input  wire logic           ref_fault,
  input  wire logic           pretsd,
  input  wire logic           tsd1,
  input  wire logic [15:0]    computed_config_checksum,
  input  wire logic [15:0]    stored_config_checksum,
  input  wire logic           checksum_valid,
  input  wire logic [NCH-1:0] pwm_long,
  input  wire logic [NCH-1:0] open_cmp,
  input  wire logic [NCH-1:0] short_cmp,
  input  wire logic [NCH-1:0] sls_cmp,
  input  wire logic           err_line_in,
  output logic                err_line_out,
  output logic                err_line_oe,
  output logic [NCH-1:0]      channel_on,
  output logic                irq
);
  // ==========================================================
  // synchronisers
  localparam int SW = 6 + 4 * NCH;
  logic [SW-1:0] raw_in;
  logic [SW-1:0] sy;
  assign raw_in = {err_line_in, tsd1, pretsd, ref_fault, supply_uv, low_supply,
                   pwm_long, open_cmp, short_cmp, sls_cmp};

  ffm_sync #(.W(SW)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (raw_in),
    .q       (sy)
  );

  logic           s_line_low;
  logic           s_tsd1;
  logic           s_pretsd;
  logic           s_ref;
  logic           s_uv;
  logic           s_lowsup;
  logic [NCH-1:0] s_pwm;
  logic [NCH-1:0] s_open;
  logic [NCH-1:0] s_short;
  logic [NCH-1:0] s_sls;
  // line sampled inverted, so a pulled-low line reads as a fault
  assign {s_line_low, s_tsd1, s_pretsd, s_ref, s_uv, s_lowsup,
          s_pwm, s_open, s_short, s_sls} = {~sy[SW-1], sy[SW-2:0]};

  // tsd2 joins the reset event: a second-limit overheat acts like a rail dropout
  logic s_por;
  logic s_good;
  logic s_good_hot;
  ffm_sync #(.W(3)) u_sync_rail (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({rail_por, tsd2, rails_good}),
    .q       ({s_por, s_good_hot, s_good})
  );

  // one free-running slot timer shared by all channels; a channel that fails
  // just after a tick waits nearly a whole slot before its first recheck
  logic retry_tick;
  ffm_retry_timer #(.CYC(RETRY_CYC)) u_retry (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (retry_tick)
  );

  // ==========================================================
  // registers
  logic [1:0]          cfg;
  logic [11:0]         mask;
  logic [11:0]         flag;
  logic [NCH-1:0]      open_flag;
  logic [NCH-1:0]      short_flag;
  logic [NCH-1:0]      sls_flag;
  logic [NCH-1:0]      channel_output_enable;
  logic [NCH-1:0]      channel_diag_enable;
  logic [NCH-1:0]      ch_fail;
  logic [1:0]          irq_status;
  logic [1:0]          irq_mask;
  ffm_state_t          state;

  // ==========================================================
  // apb write path, writes land at the access edge
  logic wr;
  logic rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  // ctrl bits are strobes, nothing stored, so they self-clear and read as zero
  logic clear_fault_cmd;
  logic clear_reset_event_cmd;
  assign clear_fault_cmd       = wr && paddr == FFM_CTRL_OFS && pwdata[FFM_CTRL_CLEAR_FAULT_CMD];
  assign clear_reset_event_cmd = wr && paddr == FFM_CTRL_OFS && pwdata[FFM_CTRL_CLRRST];

  logic one_fails_all_fail_enable;
  logic single_led_short_enable;
  assign one_fails_all_fail_enable = cfg[FFM_CFG_ONE_FAILS_ALL_FAIL_ENABLE];
  assign single_led_short_enable   = cfg[FFM_CFG_SINGLE_LED_SHORT_ENABLE];

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg                   <= FFM_CFG_RST;
      mask                  <= FFM_MASK_RST;
      channel_output_enable <= '0;
      channel_diag_enable   <= '0;
      irq_mask              <= '0;
    end else if (wr) begin
      if (is_reg(paddr, FFM_CFG_OFS))  cfg  <= pwdata[1:0];
      if (is_reg(paddr, FFM_MASK_OFS)) mask <= pwdata[11:0];
      if (is_reg(paddr, FFM_CHEN_OFS)) channel_output_enable <= pwdata[NCH-1:0];
      if (is_reg(paddr, FFM_DIAG_OFS)) channel_diag_enable   <= pwdata[NCH-1:0];
      if (is_reg(paddr, FFM_IRQM_OFS)) irq_mask <= pwdata[1:0];
    end
  end

  // ==========================================================
  // state
  logic por_event;
  assign por_event = s_por || s_good_hot;

  // init lasts one cycle; no start-up delay is kept in this block
  // reset state flow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FFM_ST_POR;
    end else begin
      case (state)
        FFM_ST_POR:  if (!por_event && s_good) state <= FFM_ST_INIT;
        FFM_ST_INIT: if (por_event) state <= FFM_ST_POR;
                     else state <= FFM_ST_RUN;
        FFM_ST_RUN:  if (por_event) state <= FFM_ST_POR;
        default:     state <= FFM_ST_POR;
      endcase
    end
  end

  // ==========================================================
  // channel detection
  logic [NCH-1:0] qual;
  logic [NCH-1:0] det_open;
  logic [NCH-1:0] det_short;
  logic [NCH-1:0] det_sls;
  logic           crc_bad;
  assign qual      = s_pwm & channel_output_enable & channel_diag_enable;
  assign det_open  = qual & s_open & ~ch_fail;
  assign det_short = qual & s_short & ~ch_fail;
  assign det_sls   = qual & s_sls & ~ch_fail & {NCH{single_led_short_enable}};
  assign crc_bad   = checksum_valid && computed_config_checksum != stored_config_checksum;

  // a failed channel stays out of detection until released, so no re-raise
  // off and retry every slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_fail <= '0;
    end else if (state != FFM_ST_RUN) begin
      ch_fail <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (det_open[i] || det_short[i] || det_sls[i])
          ch_fail[i] <= 1'b1;
        else if (retry_tick && ch_fail[i] && !s_open[i] && !s_short[i] && !s_sls[i])
          ch_fail[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // flags
  logic [11:0] ev;
  always_comb begin
    ev = '0;
    ev[FFM_F_LOWSUP] = s_lowsup;
    ev[FFM_F_SUPUV]  = s_uv;
    ev[FFM_F_REF]    = s_ref;
    ev[FFM_F_PRETSD] = s_pretsd;
    ev[FFM_F_TSD]    = s_tsd1;
    ev[FFM_F_CRC]    = crc_bad;
    ev[FFM_F_OPEN]   = |det_open;
    ev[FFM_F_SHORT]  = |det_short;
    ev[FFM_F_SLS]    = |det_sls;
  end

  logic out_ev;
  logic err_ev;
  assign out_ev = |(ev[FFM_F_SLS:FFM_F_OPEN] & ~mask[FFM_F_SLS:FFM_F_OPEN]);
  assign err_ev = out_ev || |(ev[FFM_F_CRC:FFM_F_LOWSUP] & ~mask[FFM_F_CRC:FFM_F_LOWSUP]);

  // set wins over clear, so an event in the clearing cycle is kept
  // latch, clear with set priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag       <= FFM_FLAG_RST;
      open_flag  <= '0;
      short_flag <= '0;
      sls_flag   <= '0;
    end else begin
      for (int b = FFM_F_LOWSUP; b < FFM_NFLAG; b++) begin
        if (b == FFM_F_OUT) flag[b] <= out_ev || (flag[b] && !clear_fault_cmd);
        else flag[b] <= ev[b] || (flag[b] && !clear_fault_cmd);
      end
      flag[FFM_F_RESET] <= por_event || (flag[FFM_F_RESET] && !clear_reset_event_cmd);
      flag[FFM_F_ERR]   <= por_event || err_ev || (flag[FFM_F_ERR] && !clear_fault_cmd);
      open_flag  <= det_open  | (open_flag  & {NCH{!clear_fault_cmd}});
      short_flag <= det_short | (short_flag & {NCH{!clear_fault_cmd}});
      sls_flag   <= det_sls   | (sls_flag   & {NCH{!clear_fault_cmd}});
    end
  end

  // ==========================================================
  // outputs and fault line
  logic all_off;
  logic line_drive;
  logic any_fail;
  // checksum uses its latched flag: a mismatch keeps outputs off until cleared
  // global shutdown, live conditions
  assign all_off  = state != FFM_ST_RUN || s_uv || s_ref || s_tsd1 || flag[FFM_F_CRC];
  assign any_fail = |(ch_fail & (channel_diag_enable)) || s_line_low;
  // peer pulls are only read back through the input, never fed into the drive
  // warnings excluded; single-LED short has no line mask
  assign line_drive = state == FFM_ST_POR || por_event ||
                      (s_uv && !mask[FFM_F_SUPUV]) || (s_ref && !mask[FFM_F_REF]) ||
                      (s_tsd1 && !mask[FFM_F_TSD]) ||
                      (flag[FFM_F_CRC] && !mask[FFM_F_CRC]) ||
                      (|(ch_fail & open_flag) && !mask[FFM_F_OPEN]) ||
                      (|(ch_fail & short_flag) && !mask[FFM_F_SHORT]) ||
                      |(ch_fail & sls_flag);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_on   <= '0;
      err_line_out <= 1'b0;
      err_line_oe  <= 1'b1;
    end else begin
      err_line_out <= 1'b0;
      err_line_oe  <= line_drive;
      if (all_off)
        channel_on <= '0;
      else if (one_fails_all_fail_enable && any_fail)
        channel_on <= '0;
      else
        channel_on <= channel_output_enable & ~ch_fail;
    end
  end

  // ==========================================================
  // interrupts: bit0 error, bit1 reset event
  // status set on events; set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status[0] <= err_ev ||
                       (irq_status[0] && !(wr && is_reg(paddr, FFM_IRQS_OFS) && pwdata[0]));
      irq_status[1] <= por_event ||
                       (irq_status[1] && !(wr && is_reg(paddr, FFM_IRQS_OFS) && pwdata[1]));
      irq <= |(irq_status & irq_mask);
    end
  end

  // ==========================================================
  // apb read path, zero wait states
  // unmapped reads and writes above the map answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          FFM_CFG_OFS:   prdata <= {30'h0, cfg};
          FFM_MASK_OFS:  prdata <= {20'h0, mask};
          FFM_FLAG_OFS:  prdata <= {20'h0, flag};
          FFM_OPEN_OFS:  prdata <= 32'(open_flag);
          FFM_SHORT_OFS: prdata <= 32'(short_flag);
          FFM_SLS_OFS:   prdata <= 32'(sls_flag);
          FFM_CHEN_OFS:  prdata <= 32'(channel_output_enable);
          FFM_DIAG_OFS:  prdata <= 32'(channel_diag_enable);
          FFM_CHON_OFS:  prdata <= 32'(channel_on);
          FFM_IRQS_OFS:  prdata <= {30'h0, irq_status};
          FFM_IRQM_OFS:  prdata <= {30'h0, irq_mask};
          FFM_STAT_OFS:  prdata <= {30'h0, state};
          FFM_CTRL_OFS:  prdata <= '0;
          default:       pslverr <= psel && !penable;
        endcase
      end else if (psel && !penable && pwrite && paddr > FFM_STAT_OFS) begin
        pslverr <= 1'b1;
      end
    end
  end
  logic unused_rd;
  assign unused_rd = rd;
endmodule // ffm_fault_manager

// [rtl/ffm_pkg.sv]
package ffm_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] FFM_CTRL_OFS   = 8'h00;
  localparam logic [7:0] FFM_CFG_OFS    = 8'h04;
  localparam logic [7:0] FFM_MASK_OFS   = 8'h08;
  localparam logic [7:0] FFM_FLAG_OFS   = 8'h0c;
  localparam logic [7:0] FFM_OPEN_OFS   = 8'h10;
  localparam logic [7:0] FFM_SHORT_OFS  = 8'h14;
  localparam logic [7:0] FFM_SLS_OFS    = 8'h18;
  localparam logic [7:0] FFM_CHEN_OFS   = 8'h1c;
  localparam logic [7:0] FFM_DIAG_OFS   = 8'h20;
  localparam logic [7:0] FFM_CHON_OFS   = 8'h24;
  localparam logic [7:0] FFM_IRQS_OFS   = 8'h28;
  localparam logic [7:0] FFM_IRQM_OFS   = 8'h2c;
  localparam logic [7:0] FFM_STAT_OFS   = 8'h30;
  // ==========================================================
  // ctrl bits
  localparam int FFM_CTRL_CLEAR_FAULT_CMD = 0;
  localparam int FFM_CTRL_CLRRST   = 1;
  // cfg bits
  localparam int FFM_CFG_ONE_FAILS_ALL_FAIL_ENABLE      = 0;
  localparam int FFM_CFG_SINGLE_LED_SHORT_ENABLE     = 1;
  // flag / mask bit positions
  localparam int FFM_F_RESET  = 0;
  localparam int FFM_F_ERR    = 1;
  localparam int FFM_F_LOWSUP = 2;
  localparam int FFM_F_SUPUV  = 3;
  localparam int FFM_F_REF    = 4;
  localparam int FFM_F_PRETSD = 5;
  localparam int FFM_F_TSD    = 6;
  localparam int FFM_F_CRC    = 7;
  localparam int FFM_F_OUT    = 8;
  localparam int FFM_F_OPEN   = 9;
  localparam int FFM_F_SHORT  = 10;
  localparam int FFM_F_SLS    = 11;
  localparam int FFM_NFLAG    = 12;
  // ==========================================================
  // reset values
  localparam logic [11:0] FFM_MASK_RST = 12'h000;
  localparam logic [1:0]  FFM_CFG_RST  = 2'h0;
  localparam logic [11:0] FFM_FLAG_RST = 12'h003;
  // ==========================================================
  // timing
  localparam int FFM_CLK_MHZ     = 100;
  localparam int FFM_RETRY_MS    = 10;
  localparam int FFM_RETRY_CYC   = FFM_RETRY_MS * 1000 * 1000 / 10;
  localparam int FFM_QUAL_CYC    = 4;
  // ==========================================================
  typedef enum logic [1:0] {
    FFM_ST_POR  = 2'b00,
    FFM_ST_INIT = 2'b01,
    FFM_ST_RUN  = 2'b10
  } ffm_state_t;
endpackage

// [rtl/ffm_retry_timer.sv]
module ffm_retry_timer #(
  parameter int CYC = 1000000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt;
  // one-cycle enable for retry slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt == CW'(CYC - 1)) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // ffm_retry_timer

// [rtl/ffm_sync.sv]
module ffm_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // first stage read only by second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // ffm_sync
